//--- design/rfsc_pkg.sv
// Package for the front-end trim and synthesizer calibration register slice.
// Assumes a 32-bit APB master and a calibration engine on the same clock.
package rfsc_pkg;

  localparam int NREG = 4;
  localparam int ADDR_W = 18;

  // Register indexes as printed; byte address is four times the index
  localparam logic [15:0] IDX_RX_TRIM = 16'hDF1A;
  localparam logic [15:0] IDX_TX_CFG = 16'hDF1B;
  localparam logic [15:0] IDX_PUMP_CAL = 16'hDF1C;
  localparam logic [15:0] IDX_OSC_CAL = 16'hDF1D;
  localparam logic [15:0] IDX_CAL_STATUS = 16'hDF40;

  // Slot numbers in the register array
  localparam int SLOT_RX = 0;
  localparam int SLOT_TX = 1;
  localparam int SLOT_PUMP = 2;
  localparam int SLOT_OSC = 3;

  localparam logic [15:0] REG_IDX [NREG] = '{IDX_RX_TRIM, IDX_TX_CFG, IDX_PUMP_CAL, IDX_OSC_CAL};
  localparam logic [7:0] REG_RST [NREG] = '{8'h56, 8'h10, 8'hA9, 8'h0A};
  // Writable bits; all others are unused and read zero
  localparam logic [7:0] REG_WMASK [NREG] = '{8'hFF, 8'h37, 8'hFF, 8'h3F};
  // Bits the calibration engine may update
  localparam logic [7:0] REG_HMASK [NREG] = '{8'h00, 8'h00, 8'h0F, 8'h1F};
  // Registers returned to reset on wake from the deepest sleep modes
  localparam logic REG_WAKE_CLR [NREG] = '{1'b0, 1'b0, 1'b1, 1'b0};

  // Status register bit positions
  localparam int ST_PUMP_SKIP = 0;
  localparam int ST_SW_SOURCE = 1;
  localparam int ST_CAL_SEEN = 2;
  localparam int ST_OSC_HIGH = 3;

  // Previous power mode code presented with the wake pulse
  localparam logic [1:0] PM_DEEP_TWO = 2'h2;
  localparam logic [1:0] PM_DEEP_THREE = 2'h3;

  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCESS = 2'b10
  } rfsc_apb_e;

  typedef struct packed {
    logic [1:0] input_amp_bias_trim;
    logic [1:0] amp_to_mixer_bias_trim;
    logic [1:0] rx_lo_buffer_trim;
    logic [1:0] mixer_bias_trim;
  } rfsc_rx_trim_s;

  typedef struct packed {
    logic [1:0] unused_hi;
    logic [1:0] tx_lo_buffer_trim;
    logic unused_mid;
    logic [2:0] reserved;
  } rfsc_tx_cfg_s;

  typedef struct packed {
    logic [1:0] cal_config;
    logic [1:0] pump_cal_stage_enable;
    logic [3:0] pump_current;
  } rfsc_pump_cal_s;

  typedef struct packed {
    logic [1:0] unused_hi;
    logic osc_core_high_select;
    logic [4:0] osc_current;
  } rfsc_osc_cal_s;

endpackage

//--- design/rfsc_reg8.sv
// One byte-wide configuration register with software and engine update paths.
// Assumes write strobes are single-cycle pulses on the same clock.
`timescale 1ns/1ps
module rfsc_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF,
  parameter logic [7:0] HW_MASK = 8'h00,
  parameter logic WAKE_CLR = 1'b0
) (
  input wire logic i_clk,          // System clock
  input wire logic i_rst,          // Async reset, active high
  input wire logic i_wake,         // Wake from deep sleep, pulse
  input wire logic i_sw_we,        // Software write, pulse
  input wire logic [7:0] i_sw_data, // Software write data
  input wire logic i_hw_we,        // Engine update, pulse
  input wire logic [7:0] i_hw_data, // Engine update data
  output logic [7:0] o_q           // Register value
);

  logic [7:0] val_q;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      val_q <= RST_VAL;
    end
    else if (i_wake && WAKE_CLR)
    begin
      val_q <= RST_VAL; // [R7]
    end
    else if (i_sw_we)
    begin
      // Software wins so that a stored value overrides a late result
      val_q <= i_sw_data & WR_MASK; // [R10] [R11]
    end
    else if (i_hw_we)
    begin
      val_q <= (val_q & ~HW_MASK) | (i_hw_data & HW_MASK); // [R9]
    end
  end

  assign o_q = val_q;

endmodule

//--- design/rfsc_regs.sv
// Front-end trim and synthesizer calibration registers behind an APB slave.
// Assumes calibration engine and power manager run on I_REF_CLK.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// [R1] RX trim: four 2-bit fields, resets 01,01,01,10
// [R2] TX LO buffer trim bits 5:4, reset 01
// [R3] Software writes zeros to TX bits 2:0
// [R4] Pump cal enable resets 10; zero skips stage
// [R5] Pump current result bits 3:0, reset 1001
// [R6] Calibration config bits 7:6, reset 10
// [R7] Pump cal register resets on deep wake
// [R8] Oscillator core select bit 5, reset low
// [R9] Oscillator current result, reset 01010, overridable
// [R10] Written stored results used directly when hopping
// [R11] Unused bits read zero, ignore writes
module rfsc_regs (
  input wire logic I_REF_CLK,             // System clock, 10 MHz
  input wire logic I_RST,                 // Async reset, active high
  input wire logic I_PSEL,                // APB select
  input wire logic I_PENABLE,             // APB enable
  input wire logic I_PWRITE,              // APB direction
  input wire logic [rfsc_pkg::ADDR_W-1:0] I_PADDR, // APB byte address
  input wire logic [31:0] I_PWDATA,       // APB write data
  input wire logic [3:0] I_PSTRB,         // APB byte strobes
  output logic O_PREADY,                  // APB ready
  output logic [31:0] O_PRDATA,           // APB read data
  output logic O_PSLVERR,                 // APB error, unmapped
  input wire logic I_CAL_DONE,            // Calibration results valid, pulse
  input wire logic [3:0] I_CAL_PUMP,      // Pump current result
  input wire logic [4:0] I_CAL_OSC,       // Oscillator current result
  input wire logic I_PM_WAKE,             // Return to active mode, pulse
  input wire logic [1:0] I_PM_FROM,       // Mode left at wake
  output rfsc_pkg::rfsc_rx_trim_s O_RX_TRIM,   // Receive trims
  output rfsc_pkg::rfsc_tx_cfg_s O_TX_CFG,     // Transmit config
  output rfsc_pkg::rfsc_pump_cal_s O_PUMP_CAL, // Pump calibration
  output rfsc_pkg::rfsc_osc_cal_s O_OSC_CAL,   // Oscillator calibration
  output logic O_PUMP_STAGE_EN,           // Run pump cal stage
  output logic O_LOAD_STORED              // Stored results written, pulse
);

  rfsc_pkg::rfsc_apb_e state_q;
  rfsc_pkg::rfsc_apb_e state_d;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [rfsc_pkg::NREG-1:0] sw_we;
  logic [rfsc_pkg::NREG-1:0] hw_we;
  logic [7:0] hw_data [rfsc_pkg::NREG];
  logic [7:0] reg_q [rfsc_pkg::NREG];
  logic [rfsc_pkg::NREG:0] rd_hit;
  logic [rfsc_pkg::NREG:0] wr_hit;
  logic setup;
  logic access;
  logic answer;
  logic wake_deep;
  logic sw_result_we;
  logic pump_stage_en_q;
  logic load_stored_q;
  logic sw_source_q;
  logic cal_seen_q;
  logic [7:0] status;
  logic [7:0] rd_byte;

  // One-hot register hit; top bit is the status register
  function automatic logic [rfsc_pkg::NREG:0] decode(
    input logic [rfsc_pkg::ADDR_W-1:0] addr
  );
    logic [rfsc_pkg::NREG:0] hit;
    hit = '0;
    for (int k = 0; k < rfsc_pkg::NREG; k++)
    begin
      if (addr == {rfsc_pkg::REG_IDX[k], 2'b00})
      begin
        hit[k] = 1'b1;
      end
    end
    // Status sits outside the register array
    if (addr == {rfsc_pkg::IDX_CAL_STATUS, 2'b00})
    begin
      hit[rfsc_pkg::NREG] = 1'b1;
    end
    return hit;
  endfunction

  // Lighter sleep modes keep the pump result
  function automatic logic is_deep_mode(
    input logic [1:0] mode
  );
    return (mode == rfsc_pkg::PM_DEEP_TWO) || (mode == rfsc_pkg::PM_DEEP_THREE);
  endfunction

  assign setup = I_PSEL && !I_PENABLE;
  assign access = I_PSEL && I_PENABLE && pready_q;
  assign answer = (state_q == rfsc_pkg::ST_IDLE) && setup;
  assign rd_hit = decode(I_PADDR);
  assign wr_hit = decode(I_PADDR);

  assign wake_deep = I_PM_WAKE && is_deep_mode(I_PM_FROM); // [R7]

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rfsc_pkg::ST_IDLE:
      begin
        if (setup)
        begin
          state_d = rfsc_pkg::ST_ACCESS;
        end
      end
      rfsc_pkg::ST_ACCESS:
      begin
        // A dropped select also ends the transfer
        if (access || !I_PSEL)
        begin
          state_d = rfsc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        state_d = rfsc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q <= rfsc_pkg::ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Status byte; only low bits carry state
  always_comb
  begin
    status = 8'h00;
    status[rfsc_pkg::ST_PUMP_SKIP] = !pump_stage_en_q;
    status[rfsc_pkg::ST_SW_SOURCE] = sw_source_q;
    status[rfsc_pkg::ST_CAL_SEEN] = cal_seen_q;
    status[rfsc_pkg::ST_OSC_HIGH] = reg_q[rfsc_pkg::SLOT_OSC][5];
  end

  always_comb
  begin
    rd_byte = 8'h00;
    for (int k = 0; k < rfsc_pkg::NREG; k++)
    begin
      if (rd_hit[k])
      begin
        rd_byte = reg_q[k]; // [R11]
      end
    end
    if (rd_hit[rfsc_pkg::NREG])
    begin
      rd_byte = status;
    end
  end

  // Answer is prepared in the setup cycle: no wait states
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pready_q <= 1'b0;
    end
    else if (answer)
    begin
      pready_q <= 1'b1;
    end
    else
    begin
      // High for the access cycle only
      pready_q <= 1'b0;
    end
  end

  // Unmapped addresses answer with an error and change nothing
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pslverr_q <= 1'b0;
    end
    else if (answer)
    begin
      pslverr_q <= (rd_hit == '0);
    end
    else
    begin
      pslverr_q <= 1'b0;
    end
  end

  // Read data stands only in the access cycle; the bus idles at zero
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      prdata_q <= rfsc_pkg::RDATA_RST;
    end
    else if (answer && !I_PWRITE)
    begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
    else
    begin
      prdata_q <= rfsc_pkg::RDATA_RST;
    end
  end

  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_PRDATA = prdata_q;

  // Software writes land at the access edge, low byte lane only
  always_comb
  begin
    sw_we = '0;
    for (int k = 0; k < rfsc_pkg::NREG; k++)
    begin
      sw_we[k] = access && I_PWRITE && I_PSTRB[0] && wr_hit[k];
    end
  end

  // A pump write that loses to a deep wake never lands, so no load pulse
  assign sw_result_we = (sw_we[rfsc_pkg::SLOT_PUMP] && !wake_deep) ||
                        sw_we[rfsc_pkg::SLOT_OSC];

  // Calibration engine path: result fields only
  always_comb
  begin
    hw_we = '0;
    for (int k = 0; k < rfsc_pkg::NREG; k++)
    begin
      hw_data[k] = 8'h00;
    end
    hw_we[rfsc_pkg::SLOT_PUMP] = I_CAL_DONE; // [R5]
    hw_we[rfsc_pkg::SLOT_OSC] = I_CAL_DONE; // [R9]
    hw_data[rfsc_pkg::SLOT_PUMP] = {4'h0, I_CAL_PUMP};
    hw_data[rfsc_pkg::SLOT_OSC] = {3'h0, I_CAL_OSC};
  end

  // Reset values carry the trims, enables and results
  genvar g;
  generate
    for (g = 0; g < rfsc_pkg::NREG; g++)
    begin : g_reg
      rfsc_reg8 #(
        .RST_VAL(rfsc_pkg::REG_RST[g]), // [R1] [R2] [R3] [R4] [R5] [R6] [R8] [R9]
        .WR_MASK(rfsc_pkg::REG_WMASK[g]), // [R11]
        .HW_MASK(rfsc_pkg::REG_HMASK[g]),
        .WAKE_CLR(rfsc_pkg::REG_WAKE_CLR[g])
      ) u_reg (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_wake(wake_deep),
        .i_sw_we(sw_we[g]),
        .i_sw_data(I_PWDATA[7:0]),
        .i_hw_we(hw_we[g]),
        .i_hw_data(hw_data[g]),
        .o_q(reg_q[g])
      );
    end
  endgenerate

  // Trim and calibration values reach the analog side unchanged
  assign O_RX_TRIM = rfsc_pkg::rfsc_rx_trim_s'(reg_q[rfsc_pkg::SLOT_RX]); // [R1]
  assign O_TX_CFG = rfsc_pkg::rfsc_tx_cfg_s'(reg_q[rfsc_pkg::SLOT_TX]); // [R2]
  assign O_PUMP_CAL = rfsc_pkg::rfsc_pump_cal_s'(reg_q[rfsc_pkg::SLOT_PUMP]); // [R6]
  assign O_OSC_CAL = rfsc_pkg::rfsc_osc_cal_s'(reg_q[rfsc_pkg::SLOT_OSC]); // [R8]

  // Stage enable follows the register a cycle behind it
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      pump_stage_en_q <= 1'b1;
    end
    else
    begin
      pump_stage_en_q <= (reg_q[rfsc_pkg::SLOT_PUMP][5:4] != 2'b00); // [R4]
    end
  end

  assign O_PUMP_STAGE_EN = pump_stage_en_q;

  // Pulse tells the synthesizer to take written results as they are
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      load_stored_q <= 1'b0;
    end
    else
    begin
      load_stored_q <= sw_result_we; // [R10]
    end
  end

  assign O_LOAD_STORED = load_stored_q;

  // Last source of the results; software beats a same-cycle result
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      sw_source_q <= 1'b0;
    end
    else if (sw_result_we)
    begin
      sw_source_q <= 1'b1; // [R10]
    end
    else if (I_CAL_DONE || wake_deep)
    begin
      // A deep wake discards the pump result with its source
      sw_source_q <= 1'b0;
    end
  end

  // Set wins over the wake clear so a result is flagged even when a same-cycle deep wake drops the pump value
  always_ff @(posedge I_REF_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      cal_seen_q <= 1'b0;
    end
    else if (I_CAL_DONE)
    begin
      cal_seen_q <= 1'b1;
    end
    else if (wake_deep)
    begin
      cal_seen_q <= 1'b0;
    end
  end

endmodule

//--- testbench/rfsc_regs_assertions.sv
// Checker for the trim and calibration register slice.
// Sees only the top ports; bound below the module.
`timescale 1ns/1ps
module rfsc_regs_assertions (
  input wire logic I_REF_CLK, // Clock
  input wire logic I_RST, // Reset
  input wire logic I_PSEL, // Select
  input wire logic I_PENABLE, // Enable
  input wire logic I_PWRITE, // Write
  input wire logic [rfsc_pkg::ADDR_W-1:0] I_PADDR, // Address
  input wire logic [31:0] I_PWDATA, // Data
  input wire logic [3:0] I_PSTRB, // Strobes
  input wire logic O_PREADY, // Ready
  input wire logic O_PSLVERR, // Error
  input wire logic I_CAL_DONE, // Cal pulse
  input wire logic [3:0] I_CAL_PUMP, // Pump result
  input wire logic [4:0] I_CAL_OSC, // Osc result
  input wire logic I_PM_WAKE, // Wake
  input wire logic [1:0] I_PM_FROM, // Mode left
  input wire rfsc_pkg::rfsc_rx_trim_s O_RX_TRIM, // Rx
  input wire rfsc_pkg::rfsc_tx_cfg_s O_TX_CFG, // Tx
  input wire rfsc_pkg::rfsc_pump_cal_s O_PUMP_CAL, // Pump
  input wire rfsc_pkg::rfsc_osc_cal_s O_OSC_CAL, // Osc
  input wire logic O_PUMP_STAGE_EN, // Stage
  input wire logic O_LOAD_STORED // Stored
);
  logic wr;
  logic [7:0] d;
  logic hit;
  assign wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PSTRB[0];
  assign d = I_PWDATA[7:0];
  assign hit = I_PADDR inside {18'h3_7C68, 18'h3_7C6C, 18'h3_7C70, 18'h3_7C74, 18'h3_7D00};
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  chk_rx_write: assert property (
    wr && I_PADDR == 18'h3_7C68 |=> O_RX_TRIM == $past(d)) else $error("Rx write lost");
  chk_tx_mask: assert property (
    wr && I_PADDR == 18'h3_7C6C |=> O_TX_CFG == ($past(d) & 8'h37)) else $error("Tx write bad");
  chk_pump_write: assert property (
    wr && I_PADDR == 18'h3_7C70 && !I_PM_WAKE |=> O_PUMP_CAL == $past(d))
    else $error("Pump write lost");
  chk_osc_write: assert property (
    wr && I_PADDR == 18'h3_7C74 |=> O_OSC_CAL == ($past(d) & 8'h3F)) else $error("Osc write bad");
  chk_unused_zero: assert property (
    O_TX_CFG.unused_hi == 2'b00 && O_TX_CFG.unused_mid == 1'b0 && O_OSC_CAL.unused_hi == 2'b00)
    else $error("Unused bit set");
  chk_stage_follow: assert property (
    O_PUMP_STAGE_EN == ($past(O_PUMP_CAL.pump_cal_stage_enable) != 2'b00))
    else $error("Stage enable wrong");
  chk_wake_clear: assert property (
    I_PM_WAKE && I_PM_FROM[1] |=> O_PUMP_CAL == 8'hA9) else $error("Wake clear missed");
  chk_cal_load: assert property (
    I_CAL_DONE && !I_PM_WAKE && !(I_PSEL && I_PENABLE && I_PWRITE) |=>
    O_PUMP_CAL.pump_current == $past(I_CAL_PUMP) && O_OSC_CAL.osc_current == $past(I_CAL_OSC))
    else $error("Cal result lost");
  chk_load_pulse: assert property (
    wr && (I_PADDR == 18'h3_7C74 || (I_PADDR == 18'h3_7C70 && !(I_PM_WAKE && I_PM_FROM[1])))
    |=> O_LOAD_STORED)
    else $error("Load pulse missed");
  chk_err_unmapped: assert property (
    O_PREADY |-> O_PSLVERR == !hit) else $error("Error flag wrong");
endmodule
bind rfsc_regs rfsc_regs_assertions u_rfsc_regs_assertions (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CAL_DONE(I_CAL_DONE),
  .I_CAL_PUMP(I_CAL_PUMP), .I_CAL_OSC(I_CAL_OSC), .I_PM_WAKE(I_PM_WAKE),
  .I_PM_FROM(I_PM_FROM), .O_RX_TRIM(O_RX_TRIM), .O_TX_CFG(O_TX_CFG),
  .O_PUMP_CAL(O_PUMP_CAL), .O_OSC_CAL(O_OSC_CAL), .O_PUMP_STAGE_EN(O_PUMP_STAGE_EN),
  .O_LOAD_STORED(O_LOAD_STORED)
);

//--- testbench/rfsc_regs_bench.sv
// Bench for the trim and calibration register slice.
// Drives APB, calibration and wake inputs; the checker is bound.
`timescale 1ns/1ps
module rfsc_regs_bench;
  localparam logic [17:0] AD [4] = '{18'h3_7C68, 18'h3_7C6C, 18'h3_7C70, 18'h3_7C74};
  localparam logic [7:0] RS [4] = '{8'h56, 8'h10, 8'hA9, 8'h0A};
  localparam logic [7:0] WV [4] = '{8'hFF, 8'hF8, 8'hFF, 8'hFF};
  localparam logic [7:0] RV [4] = '{8'hFF, 8'h30, 8'hFF, 8'h3F};
  localparam logic [17:0] AS = 18'h3_7D00;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic en = 1'b0;
  logic we = 1'b0;
  logic [17:0] ad = 18'h0_0000;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] st = 4'h1;
  logic cd = 1'b0;
  logic [3:0] cp = 4'h0;
  logic [4:0] co = 5'h00;
  logic wk = 1'b0;
  logic [1:0] pf = 2'h0;
  logic rdy, er, ge, stg, lst;
  logic [31:0] rdata, got;
  rfsc_pkg::rfsc_rx_trim_s rx;
  rfsc_pkg::rfsc_tx_cfg_s tx;
  rfsc_pkg::rfsc_pump_cal_s pc;
  rfsc_pkg::rfsc_osc_cal_s oc;
  int tests_run = 0;
  int n_fail = 0;
  always #50 clk = ~clk;
  rfsc_regs u_rfsc_regs (
    .I_REF_CLK(clk), .I_RST(rst), .I_PSEL(sel), .I_PENABLE(en), .I_PWRITE(we),
    .I_PADDR(ad), .I_PWDATA(wd), .I_PSTRB(st), .O_PREADY(rdy), .O_PRDATA(rdata),
    .O_PSLVERR(er), .I_CAL_DONE(cd), .I_CAL_PUMP(cp), .I_CAL_OSC(co), .I_PM_WAKE(wk),
    .I_PM_FROM(pf), .O_RX_TRIM(rx), .O_TX_CFG(tx), .O_PUMP_CAL(pc), .O_OSC_CAL(oc),
    .O_PUMP_STAGE_EN(stg), .O_LOAD_STORED(lst)
  );
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    sel <= 1'b1;
    we <= w;
    ad <= a;
    wd <= {24'h00_0000, d};
    @(posedge clk);
    en <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    got = rdata;
    ge = er;
    sel <= 1'b0;
    en <= 1'b0;
    if (rdy !== 1'b1)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(got, {24'h00_0000, e});
  endtask
  task automatic t_reset();
    check({rx, tx, pc, oc}, 32'h5610_A90A);
    check({31'h0, stg}, 32'h0000_0001);
    for (int i = 0; i < 4; i++)
      rd(AD[i], RS[i]);
  endtask
  task automatic t_rw();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, AD[i], WV[i]);
      rd(AD[i], RV[i]);
      apb(1'b1, AD[i], 8'h00);
      rd(AD[i], 8'h00);
    end
    check({31'h0, stg}, 32'h0000_0000);
    rd(AS, 8'h03);
    st <= 4'h0;
    apb(1'b1, AD[0], 8'h5A);
    st <= 4'h1;
    rd(AD[0], 8'h00);
  endtask
  task automatic t_cal();
    @(posedge clk);
    cd <= 1'b1;
    cp <= 4'h6;
    co <= 5'h15;
    @(posedge clk);
    cd <= 1'b0;
    @(posedge clk);
    check({16'h0000, pc, oc}, 32'h0000_0615);
  endtask
  task automatic t_hop();
    apb(1'b1, AD[2], 8'hA5);
    #1;
    check({31'h0, lst}, 32'h0000_0001);
    apb(1'b1, AD[3], 8'h27);
    #1;
    check({15'h0, lst, pc, oc}, 32'h0001_A527);
    rd(AS, 8'h0E);
  endtask
  task automatic t_wake();
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, AD[2], 8'h33);
      pf <= m[1:0];
      wk <= 1'b1;
      @(posedge clk);
      wk <= 1'b0;
      #1;
      check({24'h00_0000, pc}, m > 1 ? 32'h0000_00A9 : 32'h0000_0033);
    end
    // Status is read-only; deep wake cleared source and calibration flags
    apb(1'b1, AS, 8'hFF);
    check({31'h0, ge}, 32'h0000_0000);
    rd(AS, 8'h08);
  endtask
  task automatic t_mid_rst();
    apb(1'b1, AD[0], 8'hC3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check({rx, tx, pc, oc}, 32'h5610_A90A);
    check({31'h0, stg}, 32'h0000_0001);
    rd(AD[0], RS[0]);
    rd(AS, 8'h00);
  endtask
  task automatic t_err();
    apb(1'b0, 18'h3_7C78, 8'h00);
    check(got, 32'h0000_0000);
    check({31'h0, ge}, 32'h0000_0001);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_cal();
    t_hop();
    t_wake();
    t_mid_rst();
    t_err();
    finish_test();
  end
endmodule
